// file: src/wdt_params.svh
// constants for the watchdog timer registers and counter
`ifndef WDT_PARAMS_SVH
`define WDT_PARAMS_SVH
`define WDT_ADDR_CONFIG 16'hFF48
`define WDT_ADDR_RESTART 16'hFF49
`define WDT_CONFIG_RESET 8'h67
`define WDT_RESTART_READ 8'h9A
`define WDT_RESTART_KEY 8'hAC
`define WDT_FIXED_BITS 3'h3
`define WDT_CS_HI_BIT 4
`define WDT_CS_LO_BIT 3
`define WDT_PERIOD_MSB 2
`define WDT_LS_BASE_EXP 11
`define WDT_SYS_BASE_EXP 13
`define WDT_CNT_W 21
`define WDT_RESET_CAUSE_REGISTER_FLAG_BIT 4
`endif

// file: src/wdt_pkg.sv
// types shared by the watchdog timer files
package wdt_pkg;
    typedef enum logic [1:0] {
        WDT_CLK_LOW_SPEED = 2'b00,
        WDT_CLK_SYSTEM = 2'b01,
        WDT_CLK_STOPPED = 2'b10
    } wdt_clk_src_e;
    typedef enum logic [1:0] {
        WDT_ST_OPEN = 2'b00,
        WDT_ST_LOCKED = 2'b01,
        WDT_ST_HALTED = 2'b10
    } wdt_state_e;
endpackage

// file: src/wdt_sync.sv
// two-stage synchroniser for the low-speed oscillator tick
module wdt_sync (
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    input wire logic async_i,
    output logic sync_o
);
    logic meta_ff;
    logic sync_ff;
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            meta_ff <= 1'b0;
            sync_ff <= 1'b0;
        end else begin
            meta_ff <= async_i;
            sync_ff <= meta_ff;
        end
    end
    assign sync_o = sync_ff;
endmodule

// file: src/wdt_counter.sv
// overflow counter with clear, enable and selectable terminal exponent
module wdt_counter #(
    parameter int CNT_W = 21
) (
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    input wire logic clear_i,
    input wire logic inc_i,
    input wire logic [4:0] exp_i,
    output logic overflow_o,
    output logic [CNT_W-1:0] count_o
);
    logic [CNT_W-1:0] count_ff;
    logic [CNT_W-1:0] nxt_count;
    logic [CNT_W-1:0] terminal;
    assign terminal = CNT_W'((CNT_W+1)'(1) << exp_i) - CNT_W'(1);
    assign overflow_o = inc_i && (count_ff == terminal);
    assign nxt_count = clear_i ? '0 : (inc_i ? count_ff + CNT_W'(1) : count_ff);
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            count_ff <= '0;
        end else begin
            count_ff <= nxt_count;
        end
    end
    assign count_o = count_ff;
endmodule

// file: src/wdt_timer.sv
// watchdog timer: mode register, restart key register and overflow reset
`include "wdt_params.svh"
module wdt_timer
    import wdt_pkg::*;
#(
    parameter int CNT_W = `WDT_CNT_W
) (
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    input wire logic osc_fixed_i,
    input wire logic low_speed_tick_i,
    input wire logic [15:0] addr_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic bit_op_i,
    input wire logic [7:0] wdata_i,
    output logic [7:0] rdata_o,
    output logic rdata_valid_o,
    output logic wdt_reset_o,
    output logic [7:0] reset_cause_o
);
    // reset cause register lives elsewhere; only the watchdog flag bit is driven here
    logic [7:0] config_ff;
    logic [7:0] nxt_config;
    wdt_state_e state_ff;
    wdt_state_e nxt_state;
    logic [7:0] rdata_ff;
    logic rdata_valid_ff;
    logic wdt_reset_ff;
    logic flag_ff;
    logic ls_sync;
    logic ls_prev_ff;
    logic ls_tick;
    logic [4:0] exp_sel;
    logic overflow;
    logic inc;
    logic clear;
    logic [CNT_W-1:0] count;

    wire sel_config = (addr_i == `WDT_ADDR_CONFIG);
    wire sel_restart = (addr_i == `WDT_ADDR_RESTART);
    wire wr_config = wr_i && sel_config;
    wire wr_restart = wr_i && sel_restart;
    wire halted = (state_ff == WDT_ST_HALTED);
    wire [1:0] cs_raw = {config_ff[`WDT_CS_HI_BIT], config_ff[`WDT_CS_LO_BIT]};
    wire [1:0] cs_eff = osc_fixed_i ? 2'b00 : cs_raw;
    wire src_stop = cs_eff[1];
    wire src_sys = (cs_eff == 2'b01);
    wire [2:0] period = config_ff[`WDT_PERIOD_MSB:0];
    // a first write to 1x stops everything; fixed oscillator mode ignores it
    wire first_stops = !osc_fixed_i && wdata_i[`WDT_CS_HI_BIT];

    wire key_fault = wr_restart && (bit_op_i || (wdata_i != `WDT_RESTART_KEY)) && !halted;
    wire cfg_fault = wr_config && (state_ff != WDT_ST_OPEN) && !halted;
    wire key_ok = wr_restart && !bit_op_i && (wdata_i == `WDT_RESTART_KEY);

    wdt_sync u_sync (
        .clk_sys_i(clk_sys_i),
        .rst_n_i(rst_n_i),
        .async_i(low_speed_tick_i),
        .sync_o(ls_sync)
    );

    // overflow exponent, shared by both clock sources
    function automatic logic [4:0] exp_of(input logic [4:0] base, input logic [2:0] code);
        return base + {2'b00, code};
    endfunction

    assign ls_tick = ls_sync && !ls_prev_ff;
    assign exp_sel = src_sys ? exp_of(5'(`WDT_SYS_BASE_EXP), period) : exp_of(5'(`WDT_LS_BASE_EXP), period);
    assign inc = !src_stop && (src_sys ? 1'b1 : ls_tick);
    assign clear = key_ok || (wr_config && state_ff == WDT_ST_OPEN);

    wdt_counter #(
        .CNT_W(CNT_W)
    ) u_counter (
        .clk_sys_i(clk_sys_i),
        .rst_n_i(rst_n_i),
        .clear_i(clear),
        .inc_i(inc),
        .exp_i(exp_sel),
        .overflow_o(overflow),
        .count_o(count)
    );

    always_comb begin
        nxt_state = state_ff;
        nxt_config = config_ff;
        case (state_ff)
            WDT_ST_OPEN: begin
                if (wr_config) begin
                    // bits 7..5 are fixed; software is expected to write 011 there
                    nxt_config = {`WDT_FIXED_BITS, wdata_i[4:0]};
                    nxt_state = first_stops ? WDT_ST_HALTED : WDT_ST_LOCKED;
                end
            end
            WDT_ST_LOCKED: nxt_state = WDT_ST_LOCKED;
            WDT_ST_HALTED: nxt_state = WDT_ST_HALTED;
            default: nxt_state = WDT_ST_OPEN;
        endcase
    end

    wire [7:0] rd_mux = sel_config ? config_ff : (sel_restart ? `WDT_RESTART_READ : 8'h00);

    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            config_ff <= `WDT_CONFIG_RESET;
            state_ff <= WDT_ST_OPEN;
            ls_prev_ff <= 1'b0;
        end else begin
            config_ff <= nxt_config;
            state_ff <= nxt_state;
            ls_prev_ff <= ls_sync;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            rdata_ff <= 8'h00;
            rdata_valid_ff <= 1'b0;
        end else begin
            rdata_ff <= rd_i ? rd_mux : rdata_ff;
            rdata_valid_ff <= rd_i;
        end
    end

    wire fault = overflow || key_fault || cfg_fault;
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            wdt_reset_ff <= 1'b0;
        end else begin
            wdt_reset_ff <= fault;
        end
    end

    // flag must survive the internal reset it causes, so it is not cleared by rst_n_i
    // clearing belongs to the reset cause register logic outside this block
    always_ff @(posedge clk_sys_i) begin
        if (fault) begin
            flag_ff <= 1'b1;
        end else begin
            flag_ff <= flag_ff;
        end
    end

    assign rdata_o = rdata_ff;
    assign rdata_valid_o = rdata_valid_ff;
    assign wdt_reset_o = wdt_reset_ff;
    assign reset_cause_o = {3'h0, flag_ff, 4'h0};

    // assertions
    a_reset_config: assert property (@(posedge clk_sys_i) !rst_n_i |=> config_ff == `WDT_CONFIG_RESET)
        else $error("config not 67H after reset");
    a_second_write: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        (wr_config && state_ff == WDT_ST_LOCKED) |=> wdt_reset_o)
        else $error("second config write gave no reset");
    a_stop_quiet: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        (halted && !overflow) |=> !wdt_reset_o)
        else $error("reset while stopped");
    a_bad_key: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        (wr_restart && wdata_i != `WDT_RESTART_KEY && !halted) |=> wdt_reset_o)
        else $error("bad key gave no reset");
    a_bit_key: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        (wr_restart && bit_op_i && !halted) |=> wdt_reset_o)
        else $error("bit access gave no reset");
    a_restart_read: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        (rd_i && sel_restart) |=> rdata_o == `WDT_RESTART_READ)
        else $error("restart register read wrong");
    a_config_hold: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        (state_ff != WDT_ST_OPEN) |=> $stable(config_ff))
        else $error("config changed after lock");
    a_fixed_osc: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        osc_fixed_i |-> (!src_sys && !src_stop))
        else $error("fixed oscillator mode not honoured");
    a_overflow_rst: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        overflow |=> (wdt_reset_o && reset_cause_o[`WDT_RESET_CAUSE_REGISTER_FLAG_BIT]))
        else $error("overflow gave no reset");

    // counter behaviour
    a_key_clear: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        key_ok |=> (count == '0))
        else $error("key write did not clear counter");

    a_cfg_clear: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        (wr_config && state_ff == WDT_ST_OPEN) |=> (count == '0))
        else $error("config write did not clear counter");

    a_stop_hold: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        (src_stop && !clear) |=> $stable(count))
        else $error("stopped counter moved");

    a_sys_step: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        (src_sys && !clear) |=> (count == $past(count) + CNT_W'(1)))
        else $error("system clock count did not step");

    a_ls_idle: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        (!src_sys && !src_stop && !ls_tick && !clear) |=> $stable(count))
        else $error("low-speed count moved without tick");

    a_ls_step: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        (!src_sys && !src_stop && ls_tick && !clear) |=> (count == $past(count) + CNT_W'(1)))
        else $error("low-speed tick not counted");

    // register access
    a_read_pure: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        (rd_i && !wr_i) |=> ($stable(state_ff) && $stable(config_ff)))
        else $error("read changed state");

    a_read_config: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        (rd_i && sel_config) |=> (rdata_o == $past(config_ff)))
        else $error("config read wrong");

    a_valid_pulse: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        rd_i |=> rdata_valid_o)
        else $error("read gave no valid");

    a_valid_idle: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        !rd_i |=> !rdata_valid_o)
        else $error("valid without read");

    a_unmapped_read: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        (rd_i && !sel_config && !sel_restart) |=> (rdata_o == 8'h00))
        else $error("unmapped read not zero");

    // reset and write-once sequencing
    a_reset_state: assert property (@(posedge clk_sys_i)
        !rst_n_i |=> (state_ff == WDT_ST_OPEN && !wdt_reset_o && !rdata_valid_o))
        else $error("state not cleared by reset");

    a_reset_period: assert property (@(posedge clk_sys_i)
        !rst_n_i |=> (period == 3'h7 && !src_sys && !src_stop))
        else $error("reset period not maximum");

    a_halt_entry: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        (wr_config && state_ff == WDT_ST_OPEN && first_stops) |=> halted)
        else $error("stopping write did not halt");

    a_lock_entry: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        (wr_config && state_ff == WDT_ST_OPEN && !first_stops) |=> (state_ff == WDT_ST_LOCKED))
        else $error("first write did not lock");

    a_open_quiet: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        (wr_config && state_ff == WDT_ST_OPEN && !overflow) |=> !wdt_reset_o)
        else $error("first write raised reset");

    a_fixed_nohalt: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        osc_fixed_i |-> !halted)
        else $error("fixed oscillator mode halted");

    a_good_key_quiet: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        (key_ok && !overflow) |=> !wdt_reset_o)
        else $error("good key raised reset");

    // internal reset and its flag
    a_reset_source: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        wdt_reset_o |-> $past(fault))
        else $error("reset without cause");

    a_fault_flag: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        (key_fault || cfg_fault) |=> reset_cause_o[`WDT_RESET_CAUSE_REGISTER_FLAG_BIT])
        else $error("fault did not set flag");

    a_flag_on_reset: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        wdt_reset_o |-> reset_cause_o[`WDT_RESET_CAUSE_REGISTER_FLAG_BIT])
        else $error("reset without flag");

    a_flag_sticky: assert property (@(posedge clk_sys_i)
        reset_cause_o[`WDT_RESET_CAUSE_REGISTER_FLAG_BIT] |=> reset_cause_o[`WDT_RESET_CAUSE_REGISTER_FLAG_BIT])
        else $error("flag lost");

    // main scenarios
    c_good_key: cover property (@(posedge clk_sys_i) disable iff (!rst_n_i) key_ok && !halted);
    c_first_write: cover property (@(posedge clk_sys_i) disable iff (!rst_n_i) wr_config && state_ff == WDT_ST_OPEN);
    c_halted: cover property (@(posedge clk_sys_i) disable iff (!rst_n_i) wr_config && halted);
    c_overflow: cover property (@(posedge clk_sys_i) disable iff (!rst_n_i) overflow);
    c_bad_key: cover property (@(posedge clk_sys_i) disable iff (!rst_n_i) key_fault);
endmodule

// file: bench/wdt_cpu_model.sv
// cpu model issuing byte and bit memory accesses to the watchdog
`include "wdt_params.svh"
module wdt_cpu_model (
    input wire logic clk_sys_i,
    input wire logic [7:0] rdata_i,
    input wire logic rdata_valid_i,
    output logic [15:0] addr_o,
    output logic wr_o,
    output logic rd_o,
    output logic bit_op_o,
    output logic [7:0] wdata_o
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        addr_o = 16'h0000;
        wr_o = 1'b0;
        rd_o = 1'b0;
        bit_op_o = 1'b0;
        wdata_o = 8'h00;
    end
    // software never sends anything but 011 on top of a config byte
    task automatic wr(input logic [15:0] a, input logic [7:0] d, input logic bop);
        @(posedge clk_sys_i);
        addr_o <= a;
        wdata_o <= (a == `WDT_ADDR_CONFIG) ? {`WDT_FIXED_BITS, d[4:0]} : d;
        bit_op_o <= bop && (a != `WDT_ADDR_CONFIG);
        wr_o <= 1'b1;
        @(posedge clk_sys_i);
        wr_o <= 1'b0;
        bit_op_o <= 1'b0;
    endtask
    task automatic rd(input logic [15:0] a, output logic [7:0] d, output logic v);
        @(posedge clk_sys_i);
        addr_o <= a;
        rd_o <= 1'b1;
        @(posedge clk_sys_i);
        rd_o <= 1'b0;
        #1;
        d = rdata_i;
        v = rdata_valid_i;
    endtask
endmodule

// file: bench/wdt_timer_tb.sv
// self-checking bench for the watchdog timer registers
`include "wdt_params.svh"
module wdt_timer_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_sys_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic osc_fixed_i = 1'b0;
    logic tick = 1'b0;
    logic tick_en = 1'b0;
    logic [15:0] addr;
    logic wr, rd, bop, vld, wres;
    logic [7:0] wdata, rdata, cause;
    int error_cnt = 0;
    int tests_run = 0;
    int faults = 0;
    int cyc = 0;
    int lp = 1 << `WDT_SYS_BASE_EXP;
    int lp_ls = 1 << `WDT_LS_BASE_EXP;
    wdt_timer i_dut (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .osc_fixed_i(osc_fixed_i),
        .low_speed_tick_i(tick), .addr_i(addr), .wr_i(wr), .rd_i(rd), .bit_op_i(bop),
        .wdata_i(wdata), .rdata_o(rdata), .rdata_valid_o(vld), .wdt_reset_o(wres),
        .reset_cause_o(cause));
    wdt_cpu_model i_cpu (.clk_sys_i(clk_sys_i), .rdata_i(rdata), .rdata_valid_i(vld),
        .addr_o(addr), .wr_o(wr), .rd_o(rd), .bit_op_o(bop), .wdata_o(wdata));
    initial begin
        forever #4 clk_sys_i = ~clk_sys_i;
    end
    // tick period of 8 clocks keeps it well clear of the synchroniser
    always @(posedge clk_sys_i) begin
        cyc <= cyc + 1;
        if (wres === 1'b1) faults <= faults + 1;
        if (tick_en && cyc % 4 == 0) tick <= ~tick;
        if (cyc == 70000) begin
            error_cnt++;
            wrap_up();
        end
    end
    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        tests_run++;
        if (g !== e) begin
            error_cnt++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic rdv(input logic [15:0] a, input logic [7:0] e);
        logic [7:0] d;
        logic v;
        i_cpu.rd(a, d, v);
        chk("rdata", e, d);
        chk("rdata_valid", 8'h01, {7'h00, v});
    endtask
    task automatic wait_cyc(input int n);
        repeat (n) @(posedge clk_sys_i);
        #1;
    endtask
    task automatic fchk(input int n);
        wait_cyc(2);
        chk("fault count", 8'(n), 8'(faults));
    endtask
    task automatic rst(input logic fix);
        @(posedge clk_sys_i);
        rst_n_i <= 1'b0;
        osc_fixed_i <= fix;
        tick_en <= 1'b0;
        repeat (12) @(posedge clk_sys_i);
        rst_n_i <= 1'b1;
        faults = 0;
    endtask
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    initial begin
        rst(1'b0);
        rdv(`WDT_ADDR_CONFIG, `WDT_CONFIG_RESET);
        rdv(`WDT_ADDR_CONFIG, `WDT_CONFIG_RESET);
        rdv(`WDT_ADDR_RESTART, `WDT_RESTART_READ);
        rdv(16'hFF4A, 8'h00);
        i_cpu.wr(`WDT_ADDR_RESTART, `WDT_RESTART_KEY, 1'b0);
        fchk(0);
        i_cpu.wr(`WDT_ADDR_RESTART, `WDT_RESTART_READ, 1'b0);
        fchk(1);
        chk("reset_cause", 8'h10, cause);
        rst(1'b0);
        rdv(`WDT_ADDR_CONFIG, `WDT_CONFIG_RESET);
        i_cpu.wr(`WDT_ADDR_RESTART, `WDT_RESTART_KEY, 1'b1);
        fchk(1);
        $display("test keys done");
        rst(1'b0);
        i_cpu.wr(`WDT_ADDR_CONFIG, 8'h08, 1'b0);
        rdv(`WDT_ADDR_CONFIG, 8'h68);
        wait_cyc(lp - 300);
        fchk(0);
        i_cpu.wr(`WDT_ADDR_RESTART, `WDT_RESTART_KEY, 1'b0);
        wait_cyc(lp - 200);
        fchk(0);
        wait_cyc(300);
        chk("fault count", 8'h01, 8'(faults));
        $display("test overflow done");
        rst(1'b0);
        i_cpu.wr(`WDT_ADDR_CONFIG, 8'h08, 1'b0);
        i_cpu.wr(`WDT_ADDR_CONFIG, 8'h08, 1'b0);
        fchk(1);
        rst(1'b0);
        i_cpu.wr(`WDT_ADDR_CONFIG, 8'h18, 1'b0);
        i_cpu.wr(`WDT_ADDR_CONFIG, 8'h08, 1'b0);
        i_cpu.wr(`WDT_ADDR_RESTART, `WDT_RESTART_KEY, 1'b1);
        i_cpu.wr(`WDT_ADDR_RESTART, 8'h00, 1'b0);
        wait_cyc(lp + 300);
        fchk(0);
        $display("test stop done");
        rst(1'b1);
        i_cpu.wr(`WDT_ADDR_CONFIG, 8'h08, 1'b0);
        wait_cyc(lp + 300);
        fchk(0);
        tick_en <= 1'b1;
        wait_cyc(lp_ls * 8 - 200);
        fchk(0);
        wait_cyc(400);
        chk("fault count", 8'h01, 8'(faults));
        $display("test fixed oscillator done");
        wrap_up();
    end
endmodule
